//--- rtl/am_regs.svh
// Register offsets, reset values and bit positions of the activity monitor
`ifndef AM_REGS_SVH
`define AM_REGS_SVH

`define AM_ADDR_ENABLE   8'h92
`define AM_ADDR_QUALIFY  8'h93
`define AM_ADDR_POLARITY 8'h94
`define AM_ADDR_FLAGS    8'h95
`define AM_ADDR_PM_STAT  8'hbd
`define AM_ADDR_PM_DOUT  8'hbf

`define AM_RESET_BYTE    8'h00
`define AM_ALL_ONES      8'hff
`define AM_SYNC_W        12
`define AM_SYNC_IDLE     12'hfff
`define AM_PM_STAT_PAD   7'h00
`define AM_LINES_LO      7
`define AM_HOST_HI       11
`define AM_HOST_LO       8

`endif

//--- rtl/am_pkg.sv
// Types shared by the activity monitor modules
package am_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} am_sfr_req_t;

	typedef struct packed {
		logic a0;
		logic cs_n;
		logic wr_n;
		logic rd_n;
	} am_host_t;

	typedef struct packed {
		logic [7:0] enable;
		logic [7:0] qualify;
		logic [7:0] polarity;
	} am_cfg_t;

endpackage

//--- rtl/am_sync.sv
// Two-stage synchroniser for the watched lines and host strobes
`include "am_regs.svh"

module am_sync (
	input  wire logic                     clk,
	input  wire logic                     resetn,
	input  wire logic [`AM_SYNC_W-1:0]    din,
	output logic      [`AM_SYNC_W-1:0]    dout
);
	logic [`AM_SYNC_W-1:0] meta;
	logic [`AM_SYNC_W-1:0] next_meta;
	logic [`AM_SYNC_W-1:0] next_dout;

	always_comb begin
		next_meta = din;
		next_dout = meta;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta <= `AM_SYNC_IDLE;
			dout <= `AM_SYNC_IDLE;
		end else begin
			meta <= next_meta;
			dout <= next_dout;
		end
	end

endmodule

//--- rtl/am_pm_buffer.sv
// Power-management output buffer with its full flag
`include "am_regs.svh"

module am_pm_buffer (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       fw_wr,
	input  wire logic [7:0] fw_wdata,
	input  wire logic       host_rd,
	output logic      [7:0] data,
	output logic            full
);
	logic [7:0] next_data;
	logic       next_full;

	// A firmware write in the cycle of a host read keeps the flag set
	always_comb begin
		next_data = fw_wr ? fw_wdata : data;
		next_full = fw_wr | (full & ~host_rd);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data <= `AM_RESET_BYTE;
			full <= 1'b0;
		end else begin
			data <= next_data;
			full <= next_full;
		end
	end

endmodule

//--- rtl/am_activity_monitor.sv
// Activity monitor with its registers and power-event host buffer
`include "am_regs.svh"

module am_activity_monitor (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire am_pkg::am_sfr_req_t  sfr_req,
	output logic      [7:0]           sfr_rdata,
	input  wire logic [7:0]           watched_input_n,
	input  wire am_pkg::am_host_t     host,
	input  wire logic                 irq_global_enable,
	input  wire logic                 irq_priority_in,
	output logic                      irq_request,
	output logic                      irq_priority,
	output logic      [7:0]           pin_state,
	output logic      [7:0]           host_data_out,
	output logic                      host_data_oe_n,
	output logic                      host_power_event_interrupt_n
);
	import am_pkg::*;

	logic [`AM_SYNC_W-1:0] sync_raw;
	logic [`AM_SYNC_W-1:0] sync_q;
	logic [7:0]            watched;
	am_host_t              host_s;

	am_cfg_t               cfg;
	am_cfg_t               next_cfg;
	logic [7:0]            flags;
	logic [7:0]            next_flags;
	logic [7:0]            level_match;
	logic [7:0]            valid;
	logic [7:0]            set;
	logic [7:0]            keep;
	logic                  strobe_ok;

	logic                  next_irq_request;
	logic                  next_irq_priority;
	logic [7:0]            next_sfr_rdata;

	logic                  prev_rd_n;
	logic                  next_prev_rd_n;
	logic                  pm_host_rd;
	logic                  pm_fw_wr;
	logic [7:0]            pm_data;
	logic                  pm_full;
	logic [7:0]            pm_status;
	logic [7:0]            next_pin_state;
	logic [7:0]            next_host_data_out;
	logic                  next_host_data_oe_n;
	logic                  next_host_int_n;

	assign sync_raw = {host.a0, host.cs_n, host.wr_n, host.rd_n,
		watched_input_n};

	am_sync u_sync (
		.clk    (clk),
		.resetn (resetn),
		.din    (sync_raw),
		.dout   (sync_q)
	);

	assign watched = sync_q[`AM_LINES_LO:0];
	assign host_s  = am_host_t'(sync_q[`AM_HOST_HI:`AM_HOST_LO]);

	// Configuration and flag registers
	always_comb begin
		next_cfg = cfg;
		if (sfr_req.wr && sfr_req.addr == `AM_ADDR_ENABLE) begin
			next_cfg.enable = sfr_req.wdata;
		end
		if (sfr_req.wr && sfr_req.addr == `AM_ADDR_QUALIFY) begin
			next_cfg.qualify = sfr_req.wdata;
		end
		if (sfr_req.wr && sfr_req.addr == `AM_ADDR_POLARITY) begin
			next_cfg.polarity = sfr_req.wdata;
		end
	end

	always_comb begin
		strobe_ok   = ~host_s.rd_n | ~host_s.wr_n;
		level_match = ~(watched ^ cfg.polarity);
		valid       = level_match & (~cfg.qualify | {8{strobe_ok}});
		set         = valid & cfg.enable;
		keep        = `AM_ALL_ONES;
		if (sfr_req.wr && sfr_req.addr == `AM_ADDR_FLAGS) begin
			keep = sfr_req.wdata;
		end
		// sticky flag, set wins over clear
		next_flags  = (flags & keep) | set;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg   <= '{`AM_RESET_BYTE, `AM_RESET_BYTE, `AM_RESET_BYTE};
			flags <= `AM_RESET_BYTE;
		end else begin
			cfg   <= next_cfg;
			flags <= next_flags;
		end
	end

	// Interrupt request toward the core
	always_comb begin
		next_irq_request  = (|(flags & cfg.enable)) & irq_global_enable;
		next_irq_priority = irq_priority_in;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_request  <= 1'b0;
			irq_priority <= 1'b0;
		end else begin
			irq_request  <= next_irq_request;
			irq_priority <= next_irq_priority;
		end
	end

	// Register read port, unmapped offsets read zero
	assign pm_status = {`AM_PM_STAT_PAD, pm_full};

	always_comb begin
		next_sfr_rdata = `AM_RESET_BYTE;
		if (sfr_req.rd) begin
			case (sfr_req.addr)
				`AM_ADDR_ENABLE:   next_sfr_rdata = cfg.enable;
				`AM_ADDR_QUALIFY:  next_sfr_rdata = cfg.qualify;
				`AM_ADDR_POLARITY: next_sfr_rdata = cfg.polarity;
				`AM_ADDR_FLAGS:    next_sfr_rdata = flags;
				`AM_ADDR_PM_STAT:  next_sfr_rdata = pm_status;
				`AM_ADDR_PM_DOUT:  next_sfr_rdata = pm_data;
				default:           next_sfr_rdata = `AM_RESET_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sfr_rdata <= `AM_RESET_BYTE;
		end else begin
			sfr_rdata <= next_sfr_rdata;
		end
	end

	// Power-management output buffer
	assign pm_fw_wr = sfr_req.wr && sfr_req.addr == `AM_ADDR_PM_DOUT;

	// host read of the data buffer clears full
	assign pm_host_rd = prev_rd_n & ~host_s.rd_n & ~host_s.cs_n & ~host_s.a0;

	am_pm_buffer u_pm_buffer (
		.clk      (clk),
		.resetn   (resetn),
		.fw_wr    (pm_fw_wr),
		.fw_wdata (sfr_req.wdata),
		.host_rd  (pm_host_rd),
		.data     (pm_data),
		.full     (pm_full)
	);

	// Host side pins
	always_comb begin
		next_prev_rd_n      = host_s.rd_n;
		next_pin_state      = watched;
		next_host_data_oe_n = ~(~host_s.cs_n & ~host_s.rd_n);
		next_host_data_out  = host_s.a0 ? pm_status : pm_data;
		next_host_int_n     = ~pm_full;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prev_rd_n                    <= 1'b1;
			pin_state                    <= `AM_ALL_ONES;
			host_data_oe_n               <= 1'b1;
			host_data_out                <= `AM_RESET_BYTE;
			host_power_event_interrupt_n <= 1'b1;
		end else begin
			prev_rd_n                    <= next_prev_rd_n;
			pin_state                    <= next_pin_state;
			host_data_oe_n               <= next_host_data_oe_n;
			host_data_out                <= next_host_data_out;
			host_power_event_interrupt_n <= next_host_int_n;
		end
	end

	a_flag_set_sticky: assert property (
		@(posedge clk) disable iff (!resetn)
		(set != 8'h00) |=> ((flags & $past(set)) == $past(set)))
		else $error("flag not set by valid enabled line");

	a_disabled_no_set: assert property (
		@(posedge clk) disable iff (!resetn)
		1'b1 |=> ((flags & ~$past(flags) & ~$past(cfg.enable)) == 8'h00))
		else $error("flag rose on a disabled line");

	a_flag_write_clear: assert property (
		@(posedge clk) disable iff (!resetn)
		(sfr_req.wr && sfr_req.addr == `AM_ADDR_FLAGS) |=>
		(flags == (($past(flags) & $past(sfr_req.wdata)) | $past(set))))
		else $error("flag write did not clear zeros");

	a_qualify_needs_strobe: assert property (
		@(posedge clk) disable iff (!resetn)
		(!strobe_ok) |=>
		((flags & ~$past(flags) & $past(cfg.qualify)) == 8'h00))
		else $error("qualified flag set without strobe");

	a_level_polarity: assert property (
		@(posedge clk) disable iff (!resetn)
		1'b1 |=> ((flags & ~$past(flags) &
		($past(watched) ^ $past(cfg.polarity))) == 8'h00))
		else $error("flag set at inactive level");

	a_unqualified_level: assert property (
		@(posedge clk) disable iff (!resetn)
		(cfg.enable[0] && !cfg.qualify[0] &&
		watched[0] == cfg.polarity[0]) |=> flags[0])
		else $error("unqualified active level did not set flag");

	a_irq_gating: assert property (
		@(posedge clk) disable iff (!resetn)
		(irq_global_enable && (flags & cfg.enable) != 8'h00)
		|=> irq_request ##1 1'b1)
		else $error("request missing for enabled set flag");

	a_irq_global_off: assert property (
		@(posedge clk) disable iff (!resetn)
		(!irq_global_enable) |=> (!irq_request &&
		irq_priority == $past(irq_priority_in)))
		else $error("request not gated or priority wrong");

	a_pm_event_raise: assert property (
		@(posedge clk) disable iff (!resetn)
		pm_fw_wr |-> ##2 !host_power_event_interrupt_n)
		else $error("power event not raised two cycles after write");

	a_pm_host_clear: assert property (
		@(posedge clk) disable iff (!resetn)
		(pm_host_rd && !pm_fw_wr) |=> !pm_full ##1
		host_power_event_interrupt_n)
		else $error("host read did not clear full flag");

	a_full_until_read: assert property (
		@(posedge clk) disable iff (!resetn)
		(pm_full && !pm_host_rd) |=> pm_full)
		else $error("full flag dropped without a host read");

	a_host_data_read: assert property (
		@(posedge clk) disable iff (!resetn)
		(!host_s.cs_n && !host_s.rd_n && !host_s.a0) |=>
		(!host_data_oe_n && host_data_out == $past(pm_data)))
		else $error("host read did not drive buffer data");

	a_flag_clear_irq: assert property (
		@(posedge clk) disable iff (!resetn)
		(sfr_req.wr && sfr_req.addr == `AM_ADDR_FLAGS &&
		(((flags & sfr_req.wdata) | set) & cfg.enable) == 8'h00)
		|-> ##2 !irq_request)
		else $error("request stayed after flags were cleared");

	a_flags_read_back: assert property (
		@(posedge clk) disable iff (!resetn)
		(sfr_req.rd && sfr_req.addr == `AM_ADDR_FLAGS) |=>
		(sfr_rdata == $past(flags)))
		else $error("flag read returned wrong value");

	a_sync_latency: assert property (
		@(posedge clk) disable iff (!resetn)
		resetn |-> ##3 (pin_state == $past(watched_input_n, 3)))
		else $error("pin state not three cycles behind lines");

	a_reset_clear: assert property (
		@(posedge clk)
		(resetn && !$past(resetn)) |->
		(flags == 8'h00 && cfg.enable == 8'h00 &&
		cfg.qualify == 8'h00 && cfg.polarity == 8'h00))
		else $error("registers not zero after reset");

endmodule

//--- sim/am_host_model.sv
// Host side model: watched chip selects and power port strobes
module am_host_model (
	input  wire logic             clk,
	input  wire logic [7:0]       data,
	input  wire logic             oe_n,
	output logic      [7:0]       lines_n,
	output am_pkg::am_host_t      host
);
	timeunit 1ns;
	timeprecision 1ns;
	import am_pkg::*;

	// latch bit one
	// Idle chip selects sit high, as a set port latch pulls them
	initial begin
		lines_n = 8'hff;
		host = '{a0: 1'b0, cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1};
	end

	task automatic drive(input logic [7:0] v);
		@(posedge clk);
		lines_n <= v;
	endtask

	// Host write strobe with the power port not selected
	task automatic strobe();
		@(posedge clk);
		host.wr_n <= 1'b0;
		repeat (3) @(posedge clk);
		host.wr_n <= 1'b1;
	endtask

	task automatic pm_read(input logic a0, output logic [7:0] d,
		output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge clk);
		host <= '{a0: a0, cs_n: 1'b0, wr_n: 1'b1, rd_n: 1'b0};
		for (int i = 0; i < 8 && !ok; i++) begin
			@(posedge clk);
			if (oe_n === 1'b0) begin
				ok = 1'b1;
				d = data;
			end
		end
		host <= '{a0: 1'b0, cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1};
	endtask
endmodule

//--- sim/am_activity_monitor_tb.sv
// Self-checking bench for the activity monitor
`define CHK(nm, e, g) begin \
	checked++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("[FAIL] %s exp %h got %h", nm, e, g); \
	end \
end

module am_activity_monitor_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import am_pkg::*;

	logic        clk, resetn, gen, pri, ok;
	am_sfr_req_t req;
	am_host_t    host;
	logic [7:0]  rdata, lines_n, pins, hdata, d;
	logic        irq, irq_pri, oe_n, pev_n;
	int          failures = 0;
	int          checked = 0;

	am_activity_monitor dut_u (
		.clk(clk), .resetn(resetn), .sfr_req(req), .sfr_rdata(rdata),
		.watched_input_n(lines_n), .host(host),
		.irq_global_enable(gen), .irq_priority_in(pri),
		.irq_request(irq), .irq_priority(irq_pri), .pin_state(pins),
		.host_data_out(hdata), .host_data_oe_n(oe_n),
		.host_power_event_interrupt_n(pev_n)
	);

	am_host_model m (
		.clk(clk), .data(hdata), .oe_n(oe_n), .lines_n(lines_n),
		.host(host)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic sfr(input logic w, input logic [7:0] a, wd);
		@(posedge clk);
		req <= '{addr: a, wr: w, rd: !w, wdata: wd};
		@(posedge clk);
		req <= '0;
		#1 d = rdata;
	endtask

	task automatic wr(input logic [7:0] a, wd);
		sfr(1'b1, a, wd);
	endtask

	task automatic chk(input string nm, input logic [7:0] a, e);
		sfr(1'b0, a, 8'h00);
		`CHK(nm, e, d)
	endtask

	task automatic ctl(input logic g, p);
		@(posedge clk);
		gen <= g;
		pri <= p;
	endtask

	task automatic regs_zero();
		for (int a = 8'h92; a <= 8'h95; a++)
			chk("reg", 8'(a), 8'h00);
	endtask

	initial begin
		resetn = 1'b0;
		req = '0;
		gen = 1'b0;
		pri = 1'b0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		cyc(3);
		regs_zero();
		chk("unmapped", 8'h96, 8'h00);
		`CHK("pins", 8'hff, pins)
		$display("test reset done");
		// Line 0 low active, 1 disabled, 2 high active, 3 qualified
		// Lines settle before enabling, so only line 0 is active
		m.drive(8'hfa);
		wr(8'h94, 8'h04);
		wr(8'h93, 8'h08);
		wr(8'h92, 8'h0d);
		chk("enable", 8'h92, 8'h0d);
		chk("polarity", 8'h94, 8'h04);
		chk("qualify", 8'h93, 8'h08);
		cyc(4);
		`CHK("pins", 8'hfa, pins)
		chk("flags", 8'h95, 8'h01);
		// Polled mode first: global enable off
		`CHK("irq off", 1'b0, irq)
		ctl(1'b1, 1'b1);
		cyc(2);
		`CHK("irq", 1'b1, irq)
		`CHK("prio", 1'b1, irq_pri)
		m.drive(8'hff);
		cyc(4);
		chk("flags", 8'h95, 8'h05);
		m.drive(8'hfb);
		wr(8'h95, 8'hfe);
		chk("flags", 8'h95, 8'h04);
		wr(8'h95, 8'hfb);
		chk("flags", 8'h95, 8'h00);
		`CHK("irq clr", 1'b0, irq)
		$display("test level done");
		m.drive(8'hfa);
		cyc(4);
		`CHK("irq", 1'b1, irq)
		wr(8'h92, 8'h0c);
		cyc(2);
		`CHK("irq dis", 1'b0, irq)
		chk("flags", 8'h95, 8'h01);
		m.drive(8'hf3);
		wr(8'h95, 8'h00);
		cyc(4);
		chk("flags", 8'h95, 8'h00);
		m.strobe();
		cyc(4);
		chk("flags", 8'h95, 8'h08);
		$display("test qualify done");
		wr(8'hbf, 8'h5a);
		cyc(2);
		`CHK("pev", 1'b0, pev_n)
		chk("status", 8'hbd, 8'h01);
		m.pm_read(1'b0, d, ok);
		if (ok !== 1'b1) begin
			failures++;
			report_and_stop();
		end
		`CHK("host data", 8'h5a, d)
		cyc(2);
		`CHK("pev", 1'b1, pev_n)
		chk("status", 8'hbd, 8'h00);
		$display("test buffer done");
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		cyc(3);
		regs_zero();
		$display("test rereset done");
		report_and_stop();
	end
endmodule
